// ### inc/cpc_pkg.sv
// Purpose: Shared constants and types for the per-port configuration, timer and status block
// Assumes: Control bytes are numbered with bit 0 as the most significant bit
// Notes: Timer units are long; the top module takes the cycle counts as parameters
// Overview of operation
// - Line-format bits 0-1 pick control-detect table
// - Line-format bits 2-3 give 5 to 8 bits
// - Line-format bits 4-7 pick one of sixteen rates
// - Check-config bits 0-1 pick interpretation table
// - Bit 3 includes start char unless table bit 8
// - Bits 4-7 select parity, check or CRC mode
// - Four CRC polynomials; code 1101 follows length
// - Timer/mode bits 4 and 6 select transmission mode
// - Bit 5 chooses timer value or diagnostic control
// - Bit 7 selects high or low timer range
// - Low range steps of 0.071 s, later 0.284 s; code 15 jumps to 3.834 s
// - High range steps of 2.272 s per code
// - SYN sent or received reloads the timer
// - Status register clears when channel accepts status
// - Listed commands put the port in active state
// - Status condition or idle commands make port idle
// - Idle port reports listed events once, then blocks
// - Blocked port accepts four commands, else busy code
// - Idle errors held, reported after return to active
// - Status bits: device end, unit check, rest zero
// - Timer runs when code at least 2, active and not in diagnostic mode
// - Start, end, async character or expiry reload timer
// - Master clear zeroes all control bytes
package cpc_pkg;
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
  localparam int LOW_UNIT_US = 71_000;
  localparam int HIGH_UNIT_US = 2_272_000;
  localparam int LOW_UNIT_CYC = LOW_UNIT_US * CYC_PER_US;
  localparam int HIGH_UNIT_CYC = HIGH_UNIT_US * CYC_PER_US;
  localparam int PRESC_W = 30;
  localparam logic [5:0] LOW_C7_UNITS = 6'hA;
  localparam logic [5:0] LOW_STEP_UNITS = 6'h4;
  localparam logic [5:0] LOW_C15_UNITS = 6'h36;
  localparam logic [3:0] TMR_CODE_C7 = 4'h7;
  localparam logic [3:0] TMR_CODE_C15 = 4'hF;
  localparam logic [3:0] TMR_CODE_MIN = 4'h2;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  // Control byte select on the load port
  localparam logic [1:0] CB_SEL_FMT = 2'h0;
  localparam logic [1:0] CB_SEL_CHK = 2'h1;
  localparam logic [1:0] CB_SEL_TMR = 2'h2;
  localparam logic [7:0] CB_RESET = 8'h00;
  // Field positions, bit 0 of the byte being index 7
  localparam int F_TBL_HI = 7;
  localparam int F_TBL_LO = 6;
  localparam int F_LEN_HI = 5;
  localparam int F_LEN_LO = 4;
  localparam int F_RATE_HI = 3;
  localparam int F_RATE_LO = 0;
  localparam int F_START_INC = 4;
  localparam int F_PAR_HI = 3;
  localparam int F_PAR_LO = 0;
  localparam int F_TMR_HI = 7;
  localparam int F_TMR_LO = 4;
  localparam int F_MODE_A = 3;
  localparam int F_DIAG = 2;
  localparam int F_MODE_B = 1;
  localparam int F_RANGE = 0;
  localparam logic [3:0] LEN_BASE = 4'h5;
  // Status byte
  localparam int ST_DEV_END = 2;
  localparam int ST_UNIT_CHECK = 1;
  localparam logic [7:0] ST_ZERO_MASK = 8'hF9;
  localparam logic [7:0] ST_CLEAR = 8'h00;
  localparam logic [1:0] CC_OK = 2'h0;
  localparam logic [1:0] CC_BUSY = 2'h2;
  // Commands
  localparam logic [7:0] CMD_EN_OUT = 8'h01;
  localparam logic [7:0] CMD_EN_IN = 8'h02;
  localparam logic [7:0] CMD_TURN_OFF = 8'h03;
  localparam logic [7:0] CMD_DIAL = 8'h05;
  localparam logic [7:0] CMD_LOOK_SYNC = 8'h06;
  localparam logic [7:0] CMD_SEND_IDLE = 8'h09;
  localparam logic [7:0] CMD_CLR_ACTIVE = 8'h0E;
  localparam logic [7:0] CMD_LM_CLEAR = 8'h0F;
  localparam logic [7:0] CMD_SEND_SPACE = 8'h11;
  localparam logic [7:0] CMD_DISCONNECT = 8'h13;
  localparam logic [7:0] CMD_READ_PCW = 8'h16;
  localparam logic [5:0] CMD_SENSE_LOW = 6'h04;
  localparam logic [5:0] CMD_LOAD_CB_LOW = 6'h15;
  // Parity codes
  localparam logic [3:0] PAR_OFF = 4'h0;
  localparam logic [3:0] PAR_CHAR_MAX = 4'h4;
  localparam logic [3:0] PAR_EVEN_STD = 4'h5;
  localparam logic [3:0] PAR_ODD_MIN = 4'h8;
  localparam logic [3:0] PAR_ODD_MAX = 4'hB;
  localparam logic [3:0] PAR_CRC_A = 4'hC;
  localparam logic [3:0] PAR_CRC_LEN = 4'hD;
  localparam logic [3:0] PAR_CRC_CCITT = 4'hE;
  localparam logic [1:0] LEN_6BIT = 2'h1;
  localparam logic [15:0] POLY_CRC16 = 16'h8005;
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_CRC12 = 16'h080F;
  localparam logic [17:0] ASYNC_RATE_CBPS [16] = '{
    18'h011C1, 18'h01388, 18'h01630, 18'h01CFC, 18'h01D4C, 18'h02710, 18'h02AF8, 18'h0348A,
    18'h03A98, 18'h04E20, 18'h07530, 18'h0EA60, 18'h19A28, 18'h1D4C0, 18'h2BF20, 18'h3A980};

  typedef enum logic {PORT_IDLE, PORT_ACTIVE} cpc_port_e;
  typedef enum logic [2:0] {CHK_NONE, CHK_CHAR, CHK_EVEN_VRC_LRC, CHK_SPARE,
                            CHK_ODD_VRC_EVEN_LRC, CHK_CRC} cpc_chk_e;
  typedef enum logic [1:0] {CRC_16, CRC_CCITT, CRC_STRAP, CRC_12} cpc_crc_e;

  function automatic logic [5:0] cpc_low_units(input logic [3:0] code);
    logic [5:0] u;
    u = {2'h0, code};
    if (code == TMR_CODE_C15) begin
      u = LOW_C15_UNITS;
    end else if (code >= TMR_CODE_C7) begin
      u = 6'(LOW_C7_UNITS + LOW_STEP_UNITS * {2'h0, code - TMR_CODE_C7});
    end
    return u;
  endfunction
endpackage

// ### rtl/cpc_fifo.sv
// Purpose: Small synchronous FIFO for channel data headed to the line module
// Assumes: Single clock, synchronous active-low reset
// Notes: in_ready drops when full so the channel data requests stall
`timescale 1ns/1ps
module cpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cpc_fifo_s;
  cpc_fifo_s st_ff;
  cpc_fifo_s nxt_st;
  logic push;
  logic pop;

  assign in_ready = st_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_ff.cnt != '0;
  assign out_data = st_ff.mem[st_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = (st_ff.wp == AW'(DEPTH - 1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH - 1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ### rtl/cpc_port.sv
// Purpose: One adapter port: control bytes, line procedure timer, active/idle and status byte
// Assumes: All inputs synchronous to clk_sys; rst_n is the master clear
// Notes: Decoded control fields are combinational from the control byte flops
`timescale 1ns/1ps
module cpc_port
  import cpc_pkg::*;
#(
  parameter int LOW_UNIT_CYCLES = LOW_UNIT_CYC,
  parameter int HIGH_UNIT_CYCLES = HIGH_UNIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cb_wr,
  input wire logic [1:0] cb_sel,
  input wire logic [7:0] cb_wdata,
  input wire logic [1:0] cb_rd_sel,
  output logic [7:0] cb_rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic cmd_done,
  output logic [1:0] cmd_cc,
  output logic [1:0] cd_table,
  output logic [3:0] char_len,
  output logic [17:0] async_rate_cbps,
  output logic [1:0] interp_table,
  input wire logic start_ci_bit8,
  output logic start_in_block_check,
  output cpc_chk_e chk_mode,
  output cpc_crc_e crc_sel,
  input wire logic [15:0] crc_strap,
  output logic [15:0] crc_poly,
  output logic [1:0] transmission_mode_select,
  output logic diag_mode,
  input wire logic evt_start_char,
  input wire logic evt_end_char,
  input wire logic evt_async_char,
  input wire logic evt_syn_char,
  input wire logic evt_end_cond,
  input wire logic evt_check_cond,
  input wire logic evt_idle_status,
  input wire logic evt_idle_error,
  output logic timer_running,
  output logic timer_expired,
  output logic port_active,
  output logic uc_block,
  output logic status_req,
  output logic [7:0] status_byte,
  input wire logic status_ack,
  output logic data_req,
  input wire logic chan_valid,
  output logic chan_ready,
  input wire logic [7:0] chan_data,
  output logic line_valid,
  input wire logic line_ready,
  output logic [7:0] line_data
);
  typedef struct packed {
    cpc_port_e port;
    logic [7:0] fmt;
    logic [7:0] chk;
    logic [7:0] tmr;
    logic [PRESC_W-1:0] presc;
    logic [5:0] units;
    logic expired;
    logic stat_pend;
    logic [7:0] stat;
    logic stop;
    logic uc_flag;
    logic defer_err;
    logic cmd_done;
    logic [1:0] cc;
    logic [7:0] rdata;
  } cpc_state_s;
  cpc_state_s st_ff;
  cpc_state_s nxt_st;

  logic [3:0] tmr_code;
  logic range_low;
  logic [5:0] target;
  logic [PRESC_W-1:0] unit_last;
  logic unit_wrap;
  logic expire;
  logic reload;
  logic is_sense;
  logic is_load_cb;
  logic uc_allowed;
  logic is_act_cmd;
  logic is_idle_cmd;
  logic accept;
  logic fifo_in_ready;
  logic active_cond;

  // Field decode, bit 0 of each byte is the MSB
  assign cd_table = st_ff.fmt[F_TBL_HI:F_TBL_LO];
  assign char_len = LEN_BASE + {2'h0, st_ff.fmt[F_LEN_HI:F_LEN_LO]};
  assign async_rate_cbps = ASYNC_RATE_CBPS[st_ff.fmt[F_RATE_HI:F_RATE_LO]];
  assign interp_table = st_ff.chk[F_TBL_HI:F_TBL_LO];
  assign start_in_block_check = st_ff.chk[F_START_INC] && !start_ci_bit8;
  assign transmission_mode_select = {st_ff.tmr[F_MODE_A], st_ff.tmr[F_MODE_B]};
  assign diag_mode = st_ff.tmr[F_DIAG];
  assign tmr_code = st_ff.tmr[F_TMR_HI:F_TMR_LO];
  assign range_low = st_ff.tmr[F_RANGE];

  // Codes 1100 and 1110 assume software matched the character length; 1101 follows it
  always_comb begin
    logic [3:0] par;
    par = st_ff.chk[F_PAR_HI:F_PAR_LO];
    crc_sel = CRC_16;
    if (par == PAR_OFF) begin
      chk_mode = CHK_NONE;
    end else if (par <= PAR_CHAR_MAX) begin
      chk_mode = CHK_CHAR;
    end else if (par == PAR_EVEN_STD) begin
      chk_mode = CHK_EVEN_VRC_LRC;
    end else if (par < PAR_ODD_MIN) begin
      chk_mode = CHK_SPARE;
    end else if (par <= PAR_ODD_MAX) begin
      chk_mode = CHK_ODD_VRC_EVEN_LRC; // Option 8 left to software discipline
    end else begin
      chk_mode = CHK_CRC;
      if (par == PAR_CRC_LEN) begin
        crc_sel = (st_ff.fmt[F_LEN_HI:F_LEN_LO] == LEN_6BIT) ? CRC_12 : CRC_16;
      end else if (par == PAR_CRC_CCITT) begin
        crc_sel = CRC_CCITT;
      end else if (par != PAR_CRC_A) begin
        crc_sel = CRC_STRAP;
      end
    end
  end

  always_comb begin
    unique case (crc_sel)
      CRC_16: crc_poly = POLY_CRC16;
      CRC_CCITT: crc_poly = POLY_CCITT;
      CRC_STRAP: crc_poly = crc_strap;
      CRC_12: crc_poly = POLY_CRC12;
    endcase
  end

  // Line procedure timer; the prescaler restarts on reload so each expiry
  // lands exactly at the table maximum, inside every documented window
  assign timer_running = st_ff.port == PORT_ACTIVE && tmr_code >= TMR_CODE_MIN
                         && !diag_mode;
  assign target = range_low ? cpc_low_units(tmr_code) : {2'h0, tmr_code};
  assign unit_last = range_low ? PRESC_W'(LOW_UNIT_CYCLES - 1) : PRESC_W'(HIGH_UNIT_CYCLES - 1);
  assign unit_wrap = st_ff.presc >= unit_last;
  // A character event in the expiry cycle restarts the count instead of expiring
  assign expire = timer_running && unit_wrap && (st_ff.units == target - 6'h1)
                  && !(evt_start_char || evt_end_char || evt_async_char || evt_syn_char);
  assign reload = !timer_running || evt_start_char || evt_end_char || evt_async_char
                  || evt_syn_char || expire;

  // Command classes
  assign is_sense = cmd_code[5:0] == CMD_SENSE_LOW;
  assign is_load_cb = cmd_code[5:0] == CMD_LOAD_CB_LOW;
  assign uc_allowed = is_sense || is_load_cb || cmd_code == CMD_LM_CLEAR
                      || cmd_code == CMD_READ_PCW;
  assign is_act_cmd = cmd_code == CMD_EN_OUT || cmd_code == CMD_EN_IN || cmd_code == CMD_DIAL
                      || cmd_code == CMD_SEND_IDLE || cmd_code == CMD_SEND_SPACE
                      || cmd_code == CMD_DISCONNECT;
  assign is_idle_cmd = cmd_code == CMD_TURN_OFF || cmd_code == CMD_LM_CLEAR
                       || cmd_code == CMD_LOOK_SYNC || cmd_code == CMD_CLR_ACTIVE;
  assign accept = cmd_valid && (!st_ff.uc_flag || uc_allowed);
  assign active_cond = evt_end_cond || evt_check_cond || st_ff.expired
                       || (st_ff.defer_err && accept);

  always_comb begin
    logic pend;
    pend = st_ff.stat_pend;
    nxt_st = st_ff;
    nxt_st.cmd_done = cmd_valid;
    nxt_st.expired = expire;
    unique case (cb_rd_sel)
      CB_SEL_FMT: nxt_st.rdata = st_ff.fmt;
      CB_SEL_CHK: nxt_st.rdata = st_ff.chk;
      CB_SEL_TMR: nxt_st.rdata = st_ff.tmr;
      default: nxt_st.rdata = CB_RESET;
    endcase
    if (cb_wr) begin
      unique case (cb_sel)
        CB_SEL_FMT: nxt_st.fmt = cb_wdata;
        CB_SEL_CHK: nxt_st.chk = cb_wdata;
        CB_SEL_TMR: nxt_st.tmr = cb_wdata;
        default: nxt_st.fmt = st_ff.fmt;
      endcase
    end
    if (reload) begin
      nxt_st.presc = '0;
      nxt_st.units = '0;
    end else if (unit_wrap) begin
      nxt_st.presc = '0;
      nxt_st.units = st_ff.units + 6'h1;
    end else begin
      nxt_st.presc = st_ff.presc + PRESC_W'(1);
    end
    // Acceptance by the channel clears the status register and idles the port
    if (status_ack && st_ff.stat_pend) begin
      nxt_st.stat = ST_CLEAR;
      nxt_st.stat_pend = 1'b0;
      pend = 1'b0;
      nxt_st.port = PORT_IDLE;
    end
    if (cmd_valid) begin
      nxt_st.cc = accept ? CC_OK : CC_BUSY;
      if (accept) begin
        if (st_ff.uc_flag) begin
          nxt_st.uc_flag = 1'b0;
        end
        if (is_act_cmd) begin
          nxt_st.port = PORT_ACTIVE;
          nxt_st.stop = 1'b0;
        end else if (is_idle_cmd) begin
          nxt_st.port = PORT_IDLE;
          if (cmd_code == CMD_LM_CLEAR && st_ff.port == PORT_IDLE) begin
            nxt_st.defer_err = 1'b0;
          end
        end
      end
    end
    // Set after the clear so a new presentation wins over a clearing command
    if (status_ack && st_ff.stat_pend && st_ff.stat[ST_UNIT_CHECK]) begin
      nxt_st.uc_flag = 1'b1;
    end
    if (st_ff.port == PORT_ACTIVE) begin
      // Stop asking for data at once; idling waits for the presentation
      if (active_cond && !st_ff.stop && !pend) begin
        nxt_st.stat_pend = 1'b1;
        nxt_st.stop = 1'b1;
        nxt_st.stat = ST_CLEAR;
        nxt_st.stat[ST_DEV_END] = evt_end_cond || evt_check_cond;
        nxt_st.stat[ST_UNIT_CHECK] = evt_check_cond || st_ff.expired || st_ff.defer_err;
        nxt_st.defer_err = 1'b0;
      end
    end else begin
      if (evt_idle_status && !st_ff.uc_flag && !pend) begin
        nxt_st.stat_pend = 1'b1;
        nxt_st.stat = ST_CLEAR;
        nxt_st.stat[ST_UNIT_CHECK] = 1'b1;
      end
      if (evt_idle_error) begin
        nxt_st.defer_err = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0; // Master clear zeroes every control byte
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cb_rdata = st_ff.rdata;
  assign cmd_done = st_ff.cmd_done;
  assign cmd_cc = st_ff.cc;
  assign timer_expired = st_ff.expired;
  assign port_active = st_ff.port == PORT_ACTIVE;
  assign uc_block = st_ff.uc_flag;
  assign status_req = st_ff.stat_pend;
  assign status_byte = st_ff.stat;
  // Requests stop while a status condition is outstanding
  assign data_req = port_active && !st_ff.stop && !st_ff.stat_pend && fifo_in_ready;
  assign chan_ready = fifo_in_ready;

  cpc_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(chan_valid),
    .in_ready(fifo_in_ready),
    .in_data(chan_data),
    .out_valid(line_valid),
    .out_ready(line_ready),
    .out_data(line_data)
  );

  default clocking cb_main @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence seq_present;
    status_req && status_ack;
  endsequence
  sequence seq_quiet;
    !evt_idle_status && !evt_end_cond && !evt_check_cond && !timer_expired && !cmd_valid;
  endsequence

  AST_STATUS_CLEAR: assert property (seq_present ##0 seq_quiet |=> status_byte == ST_CLEAR && !status_req)
    else $error("status not cleared on acceptance");
  AST_PRESENT_IDLE: assert property (seq_present ##0 !(cmd_valid && accept && is_act_cmd) |=> !port_active)
    else $error("port not idle after presentation");
  AST_ZERO_BITS: assert property ((status_byte & ST_ZERO_MASK) == ST_CLEAR)
    else $error("reserved status bits set");
  AST_ACTIVE_CMD: assert property (cmd_valid && accept && is_act_cmd && !status_ack |=> port_active)
    else $error("active command did not activate port");
  AST_IDLE_CMD: assert property (cmd_valid && accept && is_idle_cmd |=> !port_active)
    else $error("idle command did not idle port");
  AST_NO_DREQ: assert property (status_req |-> !data_req)
    else $error("data request during status");
  AST_BUSY: assert property (cmd_valid && uc_block && !uc_allowed |=> cmd_done && cmd_cc == CC_BUSY && uc_block)
    else $error("blocked command not refused busy");
  AST_IDLE_UC: assert property (!port_active && evt_idle_status && !uc_block && !status_req |=> status_req && status_byte[ST_UNIT_CHECK])
    else $error("idle event not presented");
  AST_TIMER_STOP: assert property (tmr_code < TMR_CODE_MIN || !port_active |-> !timer_running ##1 !timer_expired)
    else $error("timer ran while stopped");
  AST_SYN_RELOAD: assert property (evt_syn_char |=> !timer_expired)
    else $error("timer expired right after reload");
  AST_CRC_LEN: assert property (st_ff.chk[F_PAR_HI:F_PAR_LO] == PAR_CRC_LEN && char_len == 4'h6 |-> crc_poly == POLY_CRC12)
    else $error("wrong polynomial for 6-bit code 1101");
  AST_CHAR_LEN: assert property (cb_wr && cb_sel == CB_SEL_FMT |=> char_len == LEN_BASE + {2'h0, $past(cb_wdata[F_LEN_HI:F_LEN_LO])})
    else $error("character length decode wrong");
endmodule

// ### sim/cpc_chan_model.sv
// Purpose: Channel model that acks status and sends data bytes
// Assumes: Drives on the falling edge, samples on the rising edge
// Notes: A released data bus toggles each cycle between the inverse of the last byte and the byte
`timescale 1ns/1ps
module cpc_chan_model (
  input wire logic clk_sys,
  input wire logic send_en,
  input wire logic [1:0] ack_dly,
  input wire logic status_req,
  input wire logic data_req,
  input wire logic chan_ready,
  output logic status_ack,
  output logic chan_valid,
  output logic [7:0] chan_data
);
  int n_sent = 0;
  int wt = 0;
  logic acc;
  initial begin
    status_ack = 1'b0;
    chan_valid = 1'b0;
    chan_data = 8'h00;
    forever begin
      @(posedge clk_sys);
      acc = chan_valid && chan_ready;
      if (acc) begin
        cpc_port_tb.line_q.push_back(chan_data);
        n_sent++;
      end
      @(negedge clk_sys);
      // One ack per presentation, after a chosen delay
      wt = (status_req && !status_ack) ? wt + 1 : 0;
      status_ack = wt > ack_dly;
      // A byte is held until taken
      if (acc || !chan_valid) begin
        chan_valid = send_en && data_req;
        chan_data = chan_valid ? 8'(8'hA5 + n_sent) : ~chan_data;
      end
    end
  end
endmodule

// ### sim/cpc_port_tb.sv
// Purpose: Self-checking bench for the port block
// Assumes: Short timer units; inputs driven on the falling edge
// Notes: Results are noted in queues and matched by a watcher
`timescale 1ns/1ps
module cpc_port_tb;
  import cpc_pkg::*;
  logic clk_sys, rst_n, cb_wr, cmd_valid, start_ci_bit8, line_ready, send_en, sr_q;
  logic [1:0] cb_sel, cb_rd_sel, interp_table, cd_table, cmd_cc, transmission_mode_select;
  logic [1:0] ack_dly, l;
  logic [7:0] cb_wdata, cb_rdata, cmd_code, evt, status_byte, chan_data, line_data, b;
  logic [3:0] char_len;
  logic [17:0] async_rate_cbps, e;
  logic [15:0] crc_strap, crc_poly;
  logic start_in_block_check, diag_mode, timer_running, timer_expired, port_active;
  logic uc_block, status_req, status_ack, data_req, chan_valid, chan_ready, line_valid;
  logic cmd_done;
  cpc_chk_e chk_mode;
  cpc_crc_e crc_sel;
  logic [7:0] line_q[$], st_q[$];
  logic [1:0] cc_q[$];
  int err_total = 0;
  int tests_run = 0;
  int seed = 1788;
  int cyc = 0;
  int n;
  int rate [16] = '{4545, 5000, 5680, 7420, 7500, 10000, 11000, 13450, 15000, 20000, 30000,
    60000, 105000, 120000, 180000, 240000};
  logic [7:0] act [6] = '{8'h01, 8'h02, 8'h05, 8'h09, 8'h11, 8'h13};
  logic [7:0] idl [4] = '{8'h03, 8'h0F, 8'h06, 8'h0E};
  logic [7:0] clr [4] = '{8'h44, 8'h0F, 8'h16, 8'h55};
  logic [7:0] tmb [6] = '{8'h21, 8'h71, 8'h81, 8'hF1, 8'h20, 8'hF0};
  int tgt [6] = '{8, 40, 56, 216, 16, 120};

  cpc_port #(.LOW_UNIT_CYCLES(4), .HIGH_UNIT_CYCLES(8)) u_dut (.*,
    .evt_start_char(evt[0]), .evt_end_char(evt[1]), .evt_async_char(evt[2]),
    .evt_syn_char(evt[3]), .evt_end_cond(evt[4]), .evt_check_cond(evt[5]),
    .evt_idle_status(evt[6]), .evt_idle_error(evt[7]));
  cpc_chan_model u_chan (.*);

  task automatic chk(input string nm, input logic [17:0] x, input logic [17:0] g);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic complete_run();
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [1:0] x);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = c;
    cc_q.push_back(x);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask
  task automatic wcb(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk_sys);
    cb_wr = 1'b1;
    cb_sel = s;
    cb_wdata = d;
    @(negedge clk_sys);
    cb_wr = 1'b0;
  endtask
  task automatic pulse(input int k);
    @(negedge clk_sys);
    evt[k] = 1'b1;
    @(negedge clk_sys);
    evt = 8'h00;
  endtask
  task automatic wait_st(output int c);
    c = 0;
    while (!status_req && c < 400) begin
      @(posedge clk_sys);
      c++;
    end
    chk("status_seen", 1, status_req);
    chk("data_req", 0, data_req);
    repeat (6) @(negedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Watcher: matches each result with the oldest note
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
    if (rst_n && cmd_done) chk("cmd_cc", cc_q.pop_front(), cmd_cc);
    if (rst_n && status_req && !sr_q) chk("status", st_q.pop_front(), status_byte);
    if (line_valid && line_ready) chk("line_data", line_q.pop_front(), line_data);
    sr_q = status_req;
  end

  initial begin
    {rst_n, cb_wr, cmd_valid, start_ci_bit8, line_ready, send_en, sr_q} = '0;
    {cb_sel, cb_wdata, cb_rd_sel, cmd_code, crc_strap, evt, ack_dly} = '0;
    repeat (7) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cb_rd_sel = 2'(i);
      @(negedge clk_sys);
      chk("cb_rdata", 0, cb_rdata);
    end
    cb_rd_sel = CB_SEL_FMT;
    for (int i = 0; i < 16; i++) begin
      b = 8'($random(seed));
      wcb(CB_SEL_FMT, b);
      chk("cd_table", b[7:6], cd_table);
      chk("char_len", 5 + b[5:4], char_len);
      chk("rate", rate[b[3:0]], async_rate_cbps);
      @(negedge clk_sys);
      chk("cb_rdata", b, cb_rdata);
    end
    for (int i = 0; i < 16; i++) begin
      b = 8'($random(seed));
      crc_strap = 16'($random(seed));
      start_ci_bit8 = b[5];
      l = (i == 12) ? 2'h2 : (i == 13 && b[0]) ? 2'h1 : 2'h3;
      wcb(CB_SEL_FMT, {2'h0, l, 4'h0});
      wcb(CB_SEL_CHK, {b[7:4], 4'(i)}); // Option 8 only as a decode
      chk("interp", b[7:6], interp_table);
      chk("start_inc", b[4] & !b[5], start_in_block_check);
      chk("chk_mode", i == 0 ? 0 : i < 5 ? 1 : i == 5 ? 2 : i < 8 ? 3 : i < 12 ? 4 : 5,
        chk_mode);
      if (i > 11) begin
        e = i == 14 ? 1 : i == 15 ? 2 : (i == 13 && l == 2'h1) ? 3 : 0;
        chk("crc_sel", e, crc_sel);
        chk("crc_poly", e == 0 ? 16'h8005 : e == 1 ? 16'h1021 : e == 2 ? crc_strap : 16'h080F,
          crc_poly);
      end
    end
    for (int i = 3; i >= 0; i--) begin
      wcb(CB_SEL_TMR, {4'h0, i[1], i == 0, i[0], 1'b0});
      chk("mode", i[1:0], transmission_mode_select);
      chk("diag", i == 0, diag_mode);
    end
    $display("test decode done");
    foreach (act[j]) begin
      cmd(act[j], CC_OK);
      chk("active", 1, port_active);
      cmd(idl[j % 4], CC_OK);
      chk("active", 0, port_active);
    end
    for (int j = 4; j < 6; j++) begin
      cmd(CMD_EN_OUT, CC_OK);
      st_q.push_back(j == 4 ? 8'h04 : 8'h06);
      pulse(j);
      wait_st(n);
      chk("active", 0, port_active);
      chk("status_clr", 0, status_byte);
      chk("uc_block", j == 5, uc_block);
    end
    cmd(CMD_EN_OUT, CC_BUSY);
    chk("active", 0, port_active);
    cmd(8'h04, CC_OK);
    foreach (clr[j]) begin
      st_q.push_back(8'h02);
      pulse(6);
      repeat (6) @(negedge clk_sys);
      chk("uc_block", 1, uc_block);
      pulse(6);
      cmd(CMD_EN_OUT, CC_BUSY);
      cmd(clr[j], CC_OK);
      chk("uc_block", 0, uc_block);
    end
    for (int j = 0; j < 2; j++) begin
      pulse(7);
      if (j == 1) cmd(CMD_LM_CLEAR, CC_OK);
      cmd(CMD_EN_OUT, CC_OK);
      st_q.push_back(j == 1 ? 8'h04 : 8'h06);
      pulse(4);
      wait_st(n);
      cmd(8'h04, CC_OK);
    end
    $display("test status done");
    for (int j = 0; j < 6; j++) begin
      wcb(CB_SEL_TMR, tmb[j]);
      ack_dly = 2'($random(seed));
      cmd(CMD_EN_OUT, CC_OK);
      st_q.push_back(8'h02);
      wait_st(n);
      chk("expiry", 1, n >= tgt[j] - 1 && n <= tgt[j] + 4);
      cmd(8'h04, CC_OK);
    end
    for (int k = 0; k < 4; k++) begin
      wcb(CB_SEL_TMR, 8'h31);
      cmd(CMD_EN_OUT, CC_OK);
      repeat (8) @(negedge clk_sys);
      pulse(k);
      st_q.push_back(8'h02);
      wait_st(n);
      chk("reload", 1, n >= 10);
      cmd(8'h04, CC_OK);
    end
    wcb(CB_SEL_TMR, 8'h11);
    cmd(CMD_EN_OUT, CC_OK);
    repeat (60) @(negedge clk_sys);
    chk("running", 0, timer_running);
    cmd(CMD_CLR_ACTIVE, CC_OK);
    $display("test timer done");
    send_en = 1'b1;
    cmd(CMD_EN_OUT, CC_OK);
    repeat (30) @(negedge clk_sys);
    chk("fill", 8, u_chan.n_sent);
    chk("chan_ready", 0, chan_ready);
    send_en = 1'b0;
    repeat (16) begin
      line_ready = 1'($random(seed));
      @(negedge clk_sys);
    end
    line_ready = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("line_valid", 0, line_valid);
    chk("sent", 8, u_chan.n_sent);
    cmd(CMD_CLR_ACTIVE, CC_OK);
    $display("test fifo done");
    complete_run();
  end
endmodule
